// ==== common/ffp_pkg.sv ====
// package: register map, field layout and protection decode for the flash fault/protection block
package ffp_pkg;
   // register byte offsets on the bus
   localparam logic [7:0] FFP_OFS_ERR_STAT = 8'h00;
   localparam logic [7:0] FFP_OFS_PROT = 8'h04;
   localparam logic [7:0] FFP_OFS_CFG = 8'h08;
   localparam logic [7:0] FFP_OFS_FLASH_STATUS_REG = 8'h0C;
   // error status fields
   localparam int FFP_SF_BIT = 0;
   localparam int FFP_DF_BIT = 1;
   // config fields
   localparam int FFP_SF_IE_BIT = 0;
   localparam int FFP_DF_IE_BIT = 1;
   localparam int FFP_IGN_SF_BIT = 4;
   // flash status fields
   localparam int FFP_VIOL_BIT = 4;
   // protection fields
   localparam int FFP_POL_BIT = 7;
   localparam int FFP_RNV_BIT = 6;
   localparam int FFP_HDIS_BIT = 5;
   localparam int FFP_HS_LSB = 3;
   localparam int FFP_LDIS_BIT = 2;
   localparam int FFP_LS_LSB = 0;
   // protection value meaning whole program flash protected
   localparam logic [7:0] FFP_PROT_FULL = 8'h7F;
   // program flash address map
   localparam logic [17:0] FFP_LOW_BASE = 18'h38000;
   localparam logic [17:0] FFP_HIGH_END = 18'h3FFFF;
   localparam logic [17:0] FFP_LOW_MIN = 18'h00400;
   localparam logic [17:0] FFP_HIGH_MIN = 18'h00800;
   localparam int FFP_NSEG = 9;
   // bus answers
   localparam logic [1:0] FFP_RESP_OKAY = 2'h0;
   localparam logic [1:0] FFP_RESP_SLVERR = 2'h2;
   // reset-time load phase
   typedef enum logic [1:0] {FFP_LD_WAIT = 2'h1, FFP_LD_DONE = 2'h2} ffp_load_e;

   // first address of each segment with uniform protection
   function automatic logic [17:0] seg_start(input int i);
      logic [17:0] a;
      a = FFP_LOW_BASE;
      case (i)
         1: a = 18'h38400;
         2: a = 18'h38800;
         3: a = 18'h39000;
         4: a = 18'h3A000;
         5: a = 18'h3C000;
         6: a = 18'h3E000;
         7: a = 18'h3F000;
         8: a = 18'h3F800;
         default: a = FFP_LOW_BASE;
      endcase
      return a;
   endfunction : seg_start

   // is this address protected under this protection byte
   function automatic logic addr_protected(input logic [7:0] p, input logic [17:0] a);
      logic [17:0] hi_start;
      logic [17:0] lo_end;
      logic hit;
      hi_start = FFP_HIGH_END - (FFP_HIGH_MIN << p[FFP_HS_LSB +: 2]) + 18'h00001;
      lo_end = FFP_LOW_BASE + (FFP_LOW_MIN << p[FFP_LS_LSB +: 2]) - 18'h00001;
      hit = (!p[FFP_HDIS_BIT] && a >= hi_start) || (!p[FFP_LDIS_BIT] && a <= lo_end);
      return (a >= FFP_LOW_BASE) && (p[FFP_POL_BIT] ? hit : !hit);
   endfunction : addr_protected

   // true when any segment of the block is protected
   function automatic logic any_protected(input logic [7:0] p);
      logic r;
      r = 1'b0;
      for (int i = 0; i < FFP_NSEG; i++)
         r = r | addr_protected(p, seg_start(i));
      return r;
   endfunction : any_protected

   // true when every area protected under old stays protected under new
   function automatic logic prot_grows(input logic [7:0] o, input logic [7:0] n);
      logic r;
      r = 1'b1;
      for (int i = 0; i < FFP_NSEG; i++)
         r = r & (!addr_protected(o, seg_start(i)) | addr_protected(n, seg_start(i)));
      return r;
   endfunction : prot_grows
endpackage : ffp_pkg

// ==== hdl/ffp_pe_gate.sv ====
// program/erase permission check against the protection byte
`timescale 1ns/100ps
module ffp_pe_gate
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [7:0] prot,
   input wire logic blocked,
   input wire logic pe_req,
   input wire logic [17:0] pe_addr,
   input wire logic pe_block_erase,
   output logic pe_accept,
   output logic pe_refuse,
   output logic pe_violation
);
   // combined protection verdict for the pending request
   logic hit;

   // block erase needs the whole block clear, others just the target
   always_comb
   begin
      if (pe_block_erase)
         hit = ffp_pkg::any_protected(prot); // [R11]
      else
         hit = ffp_pkg::addr_protected(prot, pe_addr); // [R10]
   end

   // verdict registered one cycle after the request
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         pe_accept <= 1'b0;
         pe_refuse <= 1'b0;
         pe_violation <= 1'b0;
      end
      else
      begin
         // a pending violation blocks launch without raising a new one
         pe_accept <= pe_req && !blocked && !hit; // [R23]
         pe_refuse <= pe_req && (blocked || hit); // [R23]
         pe_violation <= pe_req && !blocked && hit; // [R10]
      end
   end
endmodule : ffp_pe_gate

// ==== hdl/ffp_top.sv ====
// flash fault flags and program flash protection with an AXI4-Lite register slave
// Overview of operation
// [R1] double fault flag on 2-bit error or collision
// [R2] double fault flag clears by writing one
// [R3] single fault flag unless ignore bit set
// [R4] single fault flag clears by writing one
// [R5] genuine ECC fault sets only one flag
// [R6] collision sets both fault flags together; here only the double fault flag while the ignore bit is set
// [R7] protection writes may only enlarge protection
// [R8] protection loaded from nonvolatile byte at reset
// [R9] load double fault gives full protection
// [R10] protected program/erase refused, violation flagged
// [R11] block erase refused if any sector protected
// [R12] polarity bit seven selects protect or window
// [R13] high range disable bit five, ends top
// [R14] high size writable only while high disabled
// [R15] low range disable bit two, starts bottom
// [R16] low size writable only while low disabled
// [R17] three control bits decode eight functions
// [R18] high sizes two, four, eight, sixteen KB
// [R19] low sizes one, two, four, eight KB
// [R20] reserved bit six kept erased by software
// [R21] software may rewrite protection after load
// [R22] fault flag with enable requests interrupt
// [R23] violation flag blocks command launch
// [R24] invalid scenario writes ignored entirely
// [R25] eight-bit registers reached over the bus
`timescale 1ns/100ps
module ffp_top
(
   input wire logic clock,
   input wire logic rst,
   // register bus write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // register bus write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // register bus write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // register bus read address
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // register bus read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // array read outcome from the ecc path
   input wire logic array_read,
   input wire logic ecc_single,
   input wire logic ecc_double,
   input wire logic read_collision,
   // reset-time protection byte
   input wire logic nv_load_valid,
   input wire logic [7:0] nv_prot_byte,
   input wire logic nv_double_fault,
   // program/erase request from the command sequencer
   input wire logic pe_req,
   input wire logic [17:0] pe_addr,
   input wire logic pe_block_erase,
   output logic pe_accept,
   output logic pe_refuse,
   // status toward the command controller
   output logic launch_blocked,
   output logic double_fault_irq,
   output logic single_fault_irq
);
   // fault flags, bit 1 double, bit 0 single
   logic double_fault_flag;
   logic single_fault_flag;
   // config bits
   logic double_fault_irq_enable;
   logic single_fault_irq_enable;
   logic ignore_single_fault;
   // protection register and its load phase
   logic [7:0] prot_reg;
   ffp_pkg::ffp_load_e load_reg;
   // violation flag and its set pulse from the gate
   logic protection_violation_flag;
   logic viol_set;
   // held write address and data
   logic aw_held;
   logic w_held;
   logic [7:0] aw_addr_reg;
   logic [31:0] wdata_reg;
   logic wstrb0_reg;
   // write decode
   logic wr_go;
   logic wr_byte;
   logic wr_err_stat;
   logic wr_prot;
   logic wr_cfg;
   logic wr_flash_status_reg;
   logic wr_mapped;
   // candidate protection value
   logic [7:0] prot_next;
   // read decode
   logic [31:0] rd_data;
   logic rd_mapped;
   // fault events of this cycle
   logic df_set;
   logic sf_set;

   // permission check for program and erase
   ffp_pe_gate u_pe_gate
   (
      .clock(clock),
      .rst(rst),
      .prot(prot_reg),
      .blocked(protection_violation_flag),
      .pe_req(pe_req),
      .pe_addr(pe_addr),
      .pe_block_erase(pe_block_erase),
      .pe_accept(pe_accept),
      .pe_refuse(pe_refuse),
      .pe_violation(viol_set)
   );

   // fault event decode
   always_comb
   begin
      // collision raises both unless single faults are ignored; ecc double takes priority over single
      df_set = array_read && (ecc_double || read_collision); // [R1] [R6]
      sf_set = array_read && !ignore_single_fault
               && (read_collision || (ecc_single && !ecc_double)); // [R3] [R5] [R6]
   end

   // write takes place once both address and data are held
   always_comb
   begin
      wr_go = aw_held && w_held && !s_axi_bvalid;
      // registers are one byte wide, so only lane 0 carries data
      wr_byte = wr_go && wstrb0_reg; // [R25]
      wr_err_stat = wr_byte && aw_addr_reg == ffp_pkg::FFP_OFS_ERR_STAT;
      wr_prot = wr_byte && aw_addr_reg == ffp_pkg::FFP_OFS_PROT;
      wr_cfg = wr_byte && aw_addr_reg == ffp_pkg::FFP_OFS_CFG;
      wr_flash_status_reg = wr_byte && aw_addr_reg == ffp_pkg::FFP_OFS_FLASH_STATUS_REG;
      wr_mapped = aw_addr_reg == ffp_pkg::FFP_OFS_ERR_STAT
                  || aw_addr_reg == ffp_pkg::FFP_OFS_PROT
                  || aw_addr_reg == ffp_pkg::FFP_OFS_CFG
                  || aw_addr_reg == ffp_pkg::FFP_OFS_FLASH_STATUS_REG;
   end

   // candidate protection value built from the written byte
   always_comb
   begin
      prot_next = prot_reg;
      prot_next[ffp_pkg::FFP_POL_BIT] = wdata_reg[ffp_pkg::FFP_POL_BIT]; // [R12]
      prot_next[ffp_pkg::FFP_HDIS_BIT] = wdata_reg[ffp_pkg::FFP_HDIS_BIT]; // [R13]
      prot_next[ffp_pkg::FFP_LDIS_BIT] = wdata_reg[ffp_pkg::FFP_LDIS_BIT]; // [R15]
      // reserved bit keeps its loaded value
      prot_next[ffp_pkg::FFP_RNV_BIT] = prot_reg[ffp_pkg::FFP_RNV_BIT]; // [R20]
      // size fields only move while their range is disabled now
      if (prot_reg[ffp_pkg::FFP_HDIS_BIT])
         prot_next[ffp_pkg::FFP_HS_LSB +: 2] = wdata_reg[ffp_pkg::FFP_HS_LSB +: 2]; // [R14] [R18]
      if (prot_reg[ffp_pkg::FFP_LDIS_BIT])
         prot_next[ffp_pkg::FFP_LS_LSB +: 2] = wdata_reg[ffp_pkg::FFP_LS_LSB +: 2]; // [R16] [R19]
   end

   // read data mux; unused upper bits read zero
   always_comb
   begin
      rd_data = 32'h00000000;
      rd_mapped = 1'b1;
      unique case (s_axi_araddr)
         ffp_pkg::FFP_OFS_ERR_STAT:
         begin
            rd_data[ffp_pkg::FFP_DF_BIT] = double_fault_flag;
            rd_data[ffp_pkg::FFP_SF_BIT] = single_fault_flag;
         end
         ffp_pkg::FFP_OFS_PROT:
            rd_data[7:0] = prot_reg; // [R24]
         ffp_pkg::FFP_OFS_CFG:
         begin
            rd_data[ffp_pkg::FFP_DF_IE_BIT] = double_fault_irq_enable;
            rd_data[ffp_pkg::FFP_SF_IE_BIT] = single_fault_irq_enable;
            rd_data[ffp_pkg::FFP_IGN_SF_BIT] = ignore_single_fault;
         end
         ffp_pkg::FFP_OFS_FLASH_STATUS_REG:
            rd_data[ffp_pkg::FFP_VIOL_BIT] = protection_violation_flag;
         default:
            rd_mapped = 1'b0;
      endcase
   end

   // write address channel: hold until the write is done
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         aw_held <= 1'b0;
         aw_addr_reg <= 8'h00;
         s_axi_awready <= 1'b1;
      end
      else if (s_axi_awvalid && s_axi_awready)
      begin
         aw_held <= 1'b1;
         aw_addr_reg <= s_axi_awaddr;
         s_axi_awready <= 1'b0;
      end
      else if (wr_go)
         aw_held <= 1'b0;
      else if (s_axi_bvalid && s_axi_bready)
         s_axi_awready <= 1'b1;
   end

   // write data channel: taken independently of the address
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         w_held <= 1'b0;
         wdata_reg <= 32'h00000000;
         wstrb0_reg <= 1'b0;
         s_axi_wready <= 1'b1;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         w_held <= 1'b1;
         wdata_reg <= s_axi_wdata;
         wstrb0_reg <= s_axi_wstrb[0];
         s_axi_wready <= 1'b0;
      end
      else if (wr_go)
         w_held <= 1'b0;
      else if (s_axi_bvalid && s_axi_bready)
         s_axi_wready <= 1'b1;
   end

   // write response one cycle after the write takes place
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= ffp_pkg::FFP_RESP_OKAY;
      end
      else if (wr_go)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_mapped ? ffp_pkg::FFP_RESP_OKAY : ffp_pkg::FFP_RESP_SLVERR;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // read channel: data one cycle after the address is taken
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= ffp_pkg::FFP_RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_data; // [R25]
         s_axi_rresp <= rd_mapped ? ffp_pkg::FFP_RESP_OKAY : ffp_pkg::FFP_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // double fault flag; a new fault wins over a same-cycle clear
   always_ff @(posedge clock)
   begin
      if (rst)
         double_fault_flag <= 1'b0;
      else if (df_set)
         double_fault_flag <= 1'b1; // [R1]
      else if (wr_err_stat && wdata_reg[ffp_pkg::FFP_DF_BIT])
         double_fault_flag <= 1'b0; // [R2]
   end

   // single fault flag; same set-over-clear priority
   always_ff @(posedge clock)
   begin
      if (rst)
         single_fault_flag <= 1'b0;
      else if (sf_set)
         single_fault_flag <= 1'b1; // [R3]
      else if (wr_err_stat && wdata_reg[ffp_pkg::FFP_SF_BIT])
         single_fault_flag <= 1'b0; // [R4]
   end

   // config register: interrupt enables and ignore-single-fault
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         double_fault_irq_enable <= 1'b0;
         single_fault_irq_enable <= 1'b0;
         ignore_single_fault <= 1'b0;
      end
      else if (wr_cfg)
      begin
         double_fault_irq_enable <= wdata_reg[ffp_pkg::FFP_DF_IE_BIT];
         single_fault_irq_enable <= wdata_reg[ffp_pkg::FFP_SF_IE_BIT];
         ignore_single_fault <= wdata_reg[ffp_pkg::FFP_IGN_SF_BIT];
      end
   end

   // interrupt requests follow flag and enable with one flop of delay
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         double_fault_irq <= 1'b0;
         single_fault_irq <= 1'b0;
      end
      else
      begin
         double_fault_irq <= double_fault_flag && double_fault_irq_enable; // [R22]
         single_fault_irq <= single_fault_flag && single_fault_irq_enable; // [R22]
      end
   end

   // violation flag; set by refused program/erase, write one clears
   always_ff @(posedge clock)
   begin
      if (rst)
         protection_violation_flag <= 1'b0;
      else if (viol_set)
         protection_violation_flag <= 1'b1; // [R10]
      else if (wr_flash_status_reg && wdata_reg[ffp_pkg::FFP_VIOL_BIT])
         protection_violation_flag <= 1'b0;
   end

   // launch block mirrors the violation flag toward the sequencer
   always_ff @(posedge clock)
   begin
      if (rst)
         launch_blocked <= 1'b0;
      else if (viol_set)
         launch_blocked <= 1'b1; // [R23]
      else if (wr_flash_status_reg && wdata_reg[ffp_pkg::FFP_VIOL_BIT])
         launch_blocked <= 1'b0;
   end

   // protection register: fully protected until the reset-time load
   // lands, so nothing in the program flash can be erased in the window before it
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         prot_reg <= ffp_pkg::FFP_PROT_FULL;
         load_reg <= ffp_pkg::FFP_LD_WAIT;
      end
      else
      begin
         unique case (load_reg)
            ffp_pkg::FFP_LD_WAIT:
            begin
               if (nv_load_valid)
               begin
                  load_reg <= ffp_pkg::FFP_LD_DONE;
                  // a bad read of the stored byte locks everything
                  if (nv_double_fault)
                     prot_reg <= ffp_pkg::FFP_PROT_FULL; // [R9]
                  else
                     prot_reg <= nv_prot_byte; // [R8]
               end
            end
            ffp_pkg::FFP_LD_DONE:
            begin
               // scenario moves that would lose protection are dropped
               if (wr_prot && ffp_pkg::prot_grows(prot_reg, prot_next))
                  prot_reg <= prot_next; // [R7] [R17] [R21] [R24]
            end
         endcase
      end
   end
endmodule : ffp_top

// ==== tb/ffp_checker.sv ====
// port-level assertions for the flash fault and protection block
`timescale 1ns/100ps
module ffp_checker
(
   input wire logic clock,
   input wire logic rst,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic pe_req,
   input wire logic [17:0] pe_addr,
   input wire logic pe_block_erase,
   input wire logic pe_accept,
   input wire logic pe_refuse,
   input wire logic launch_blocked
);
   // single clock domain
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   // a program/erase request taken at an edge
   sequence seq_pe_taken;
      pe_req;
   endsequence
   // exactly one of the two answers
   sequence seq_one_answer;
      pe_accept ^ pe_refuse;
   endsequence
   // address and data of a write taken together
   sequence seq_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence

   a_pe_one_answer: assert property (seq_pe_taken |=> seq_one_answer)
      else $error("request without exactly one answer");
   a_blocked_refuse: assert property (seq_pe_taken and launch_blocked |=> pe_refuse)
      else $error("request accepted while violation flag set");
   // the flag is registered from the violation pulse, which comes with the refusal, so it rises one edge after it
   a_flag_with_refuse: assert property ($rose(launch_blocked) |-> $past(pe_refuse))
      else $error("violation flag rose without a refusal");
   // addresses below the program flash are never protected
   a_low_accept: assert property (pe_req && !pe_block_erase && pe_addr < 18'h38000 && !launch_blocked
      |=> pe_accept)
      else $error("unprotected request refused");
   a_wr_answer: assert property (seq_wr_taken |-> ##2 s_axi_bvalid)
      else $error("write response late");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before taken");
   a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h000000)
      else $error("read answer late or wider than a byte");
   a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data changed before taken");
   // reset is the cause here, so nothing disables it
   a_reset_quiet: assert property (disable iff (1'b0) rst |=> !s_axi_bvalid && !s_axi_rvalid && !launch_blocked)
      else $error("outputs active after reset");
endmodule : ffp_checker

bind ffp_top ffp_checker u_ffp_checker (.clock, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
   .s_axi_rready, .pe_req, .pe_addr, .pe_block_erase, .pe_accept, .pe_refuse, .launch_blocked);

// ==== tb/tb.sv ====
// self-checking bench for the flash fault and protection block
`timescale 1ns/100ps
module tb;
   // protection row: byte written, byte read back, probe address, block erase, accepted
   typedef struct packed {logic [7:0] wr; logic [7:0] rd; logic [17:0] a; logic blk; logic acc;} ffp_row_s;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF; // full strobes only
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic array_read = 1'b0, ecc_single = 1'b0, ecc_double = 1'b0, read_collision = 1'b0;
   logic nv_load_valid = 1'b0, nv_double_fault = 1'b0, pe_req = 1'b0, pe_block_erase = 1'b0;
   logic [7:0] nv_prot_byte = 8'h00;
   logic [17:0] pe_addr = 18'h00000;
   logic pe_accept, pe_refuse, launch_blocked, double_fault_irq, single_fault_irq;
   int mismatches = 0;
   int checks_done = 0;
   // protection grows; shrinking writes mixed in
   ffp_row_s rows [10] = '{'{8'hFA, 8'hFA, 18'h38FFF, 1'b0, 1'b0}, '{8'hFA, 8'hFA, 18'h39000, 1'b0, 1'b1},
      '{8'hDA, 8'hDA, 18'h3C000, 1'b0, 1'b0}, '{8'hDA, 8'hDA, 18'h3BFFF, 1'b0, 1'b1},
      '{8'hFA, 8'hDA, 18'h3FFFF, 1'b0, 1'b0}, '{8'hC2, 8'hDA, 18'h3C000, 1'b0, 1'b0},
      '{8'hDA, 8'hDA, 18'h39000, 1'b1, 1'b0}, '{8'hDA, 8'hDA, 18'h10000, 1'b0, 1'b1},
      '{8'h7E, 8'h7E, 18'h39000, 1'b0, 1'b0}, '{8'h7A, 8'h7E, 18'h38000, 1'b0, 1'b0}};

   ffp_top u_ffp_top (.clock, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .array_read, .ecc_single,
      .ecc_double, .read_collision, .nv_load_valid, .nv_prot_byte, .nv_double_fault, .pe_req, .pe_addr,
      .pe_block_erase, .pe_accept, .pe_refuse, .launch_blocked, .double_fault_irq, .single_fault_irq);

   // 200 MHz clock
   always #2.5 clock = ~clock;

   // exact four-state compare, so an unknown never matches
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // bus write; ready seen mid-cycle, it moves only on rising edges
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
      logic ap, wp, ag, wg;
      ap = 1'b1;
      wp = 1'b1;
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (ap || wp)
      begin
         @(negedge clock);
         ag = ap && s_axi_awready;
         wg = wp && s_axi_wready;
         @(posedge clock);
         if (ag) s_axi_awvalid <= 1'b0;
         if (wg) s_axi_wvalid <= 1'b0;
         ap = ap && !ag;
         wp = wp && !wg;
      end
      do @(negedge clock); while (!s_axi_bvalid);
      chk(32'(s_axi_bresp), 32'(er));
      @(posedge clock);
      s_axi_bready <= 1'b1;
      @(posedge clock);
      s_axi_bready <= 1'b0;
   endtask : wr

   // bus read of one register byte, compared on arrival
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clock);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(negedge clock); while (!s_axi_arready);
      @(posedge clock);
      s_axi_arvalid <= 1'b0;
      do @(negedge clock); while (!s_axi_rvalid);
      chk(s_axi_rdata, {24'h000000, exp});
      chk(32'(s_axi_rresp), 32'(ffp_pkg::FFP_RESP_OKAY));
      @(posedge clock);
      s_axi_rready <= 1'b1;
      @(posedge clock);
      s_axi_rready <= 1'b0;
   endtask : rd

   // one program/erase request; refusal optionally cleared
   task automatic pe(input logic [17:0] a, input logic b, input logic acc, input logic clr);
      @(posedge clock);
      pe_addr <= a;
      pe_block_erase <= b;
      pe_req <= 1'b1;
      @(posedge clock);
      pe_req <= 1'b0;
      @(negedge clock);
      chk(32'({pe_accept, pe_refuse}), 32'({acc, !acc}));
      if (clr && !acc)
      begin
         rd(ffp_pkg::FFP_OFS_FLASH_STATUS_REG, 8'h10);
         wr(ffp_pkg::FFP_OFS_FLASH_STATUS_REG, 8'h10, ffp_pkg::FFP_RESP_OKAY);
      end
   endtask : pe

   // array read pulse, then wait out flag and irq stages
   task automatic fault(input logic s, input logic d, input logic c);
      @(posedge clock);
      {array_read, ecc_single, ecc_double, read_collision} <= {1'b1, s, d, c};
      @(posedge clock);
      {array_read, ecc_single, ecc_double, read_collision} <= 4'h0;
      @(posedge clock);
      @(negedge clock);
   endtask : fault

   // reset-time protection byte delivery
   task automatic load(input logic [7:0] b, input logic f);
      @(posedge clock);
      {nv_load_valid, nv_prot_byte, nv_double_fault} <= {1'b1, b, f};
      @(posedge clock);
      nv_load_valid <= 1'b0;
   endtask : load

   // verdict; reached from the main sequence or the watchdog
   task automatic end_of_test();
      $display("checks_done %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : end_of_test

   // watchdog: run needs a few hundred cycles; allows 20000
   initial
   begin
      #100000;
      mismatches++;
      end_of_test();
   end

   initial
   begin
      repeat (12) @(posedge clock);
      rst <= 1'b0;
      rd(ffp_pkg::FFP_OFS_PROT, 8'h7F);
      load(8'hFF, 1'b0);
      rd(ffp_pkg::FFP_OFS_PROT, 8'hFF);
      foreach (rows[i])
      begin
         wr(ffp_pkg::FFP_OFS_PROT, rows[i].wr, ffp_pkg::FFP_RESP_OKAY);
         rd(ffp_pkg::FFP_OFS_PROT, rows[i].rd);
         pe(rows[i].a, rows[i].blk, rows[i].acc, 1'b1);
      end
      // violation left standing blocks even an unprotected address
      pe(18'h39000, 1'b0, 1'b0, 1'b0);
      // the flag lands one edge after the refusal
      @(negedge clock);
      chk(32'(launch_blocked), 32'h1);
      pe(18'h10000, 1'b0, 1'b0, 1'b0);
      wr(ffp_pkg::FFP_OFS_FLASH_STATUS_REG, 8'h10, ffp_pkg::FFP_RESP_OKAY);
      rd(ffp_pkg::FFP_OFS_FLASH_STATUS_REG, 8'h00);
      // fault flags with both interrupt enables on
      wr(ffp_pkg::FFP_OFS_CFG, 8'h03, ffp_pkg::FFP_RESP_OKAY);
      fault(1'b1, 1'b0, 1'b0);
      chk(32'({double_fault_irq, single_fault_irq}), 32'h1);
      wr(ffp_pkg::FFP_OFS_ERR_STAT, 8'h00, ffp_pkg::FFP_RESP_OKAY);
      rd(ffp_pkg::FFP_OFS_ERR_STAT, 8'h01);
      wr(ffp_pkg::FFP_OFS_ERR_STAT, 8'h01, ffp_pkg::FFP_RESP_OKAY);
      fault(1'b0, 1'b1, 1'b0);
      chk(32'({double_fault_irq, single_fault_irq}), 32'h2);
      rd(ffp_pkg::FFP_OFS_ERR_STAT, 8'h02);
      wr(ffp_pkg::FFP_OFS_ERR_STAT, 8'h01, ffp_pkg::FFP_RESP_OKAY);
      rd(ffp_pkg::FFP_OFS_ERR_STAT, 8'h02);
      wr(ffp_pkg::FFP_OFS_ERR_STAT, 8'h02, ffp_pkg::FFP_RESP_OKAY);
      fault(1'b1, 1'b1, 1'b0);
      rd(ffp_pkg::FFP_OFS_ERR_STAT, 8'h02);
      wr(ffp_pkg::FFP_OFS_ERR_STAT, 8'h02, ffp_pkg::FFP_RESP_OKAY);
      fault(1'b0, 1'b0, 1'b1);
      rd(ffp_pkg::FFP_OFS_ERR_STAT, 8'h03);
      wr(ffp_pkg::FFP_OFS_ERR_STAT, 8'h03, ffp_pkg::FFP_RESP_OKAY);
      // ignore-single-fault set: a corrected error leaves no trace
      wr(ffp_pkg::FFP_OFS_CFG, 8'h13, ffp_pkg::FFP_RESP_OKAY);
      fault(1'b1, 1'b0, 1'b0);
      rd(ffp_pkg::FFP_OFS_ERR_STAT, 8'h00);
      chk(32'({double_fault_irq, single_fault_irq}), 32'h0);
      wr(8'h20, 8'hFF, ffp_pkg::FFP_RESP_SLVERR);
      // second reset in mid-run; a faulty load must leave everything protected
      @(posedge clock);
      rst <= 1'b1;
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      rd(ffp_pkg::FFP_OFS_ERR_STAT, 8'h00);
      load(8'hFF, 1'b1);
      rd(ffp_pkg::FFP_OFS_PROT, ffp_pkg::FFP_PROT_FULL);
      load(8'hFF, 1'b0);
      rd(ffp_pkg::FFP_OFS_PROT, ffp_pkg::FFP_PROT_FULL);
      pe(18'h3FFFF, 1'b0, 1'b0, 1'b1);
      end_of_test();
   end
endmodule : tb
